// ### mode_map_pkg.sv
// constants, field layouts and carrier types for the mode, map and port setup block
// assumes one 100 MHz clock, synchronous active-low reset and a byte-wide register port
// Operation
// - mode pin levels caught at reset release set mode bits and the map
// - expanded modes: ports A,B address; C,D data wide, C alone narrow, C and D narrow with port D emulation
// - single-chip: no bus roles, port A pins follow its direction register; normal narrow expanded drives port E bit 3 high
// - every expanded mode drives port F bit 5 as a chip select
// - registers decode at 0x0000-0x01FF, RAM at 0x0800-0x0BFF
// - EEPROM at 0x1000-0x1FFF expanded, 0xF000-0xFFFF single-chip
// - mapping control always readable; one write in normal modes, any in special
// - expanded and window enabled: position bit picks 0x0000 or 0x0400 window
// - narrow space bit makes the 512-byte select space 8-bit over port C
// - expansion windows only in expanded modes; three windows, two fixed
// - expanded wide: port C and D data and direction accesses go external
// - narrow special expanded with port D emulation: port D registers go external
// - expanded with port E emulation: port E registers go external
// - port A carries upper address bits externally, else general I/O; registers absent when expanded or in peripheral mode
// - port A direction bit 1 output, 0 input; accessible while mapped
// - expanded without port E emulation: port E pins are bus controls chosen by the assignment register
package mode_map_pkg;
    // register port offsets
    localparam logic [15:0] OFS_PORT_A_DATA = 16'h0000;
    localparam logic [15:0] OFS_PORT_A_DIR  = 16'h0002;
    localparam logic [15:0] OFS_PORT_C_DATA = 16'h0004;
    localparam logic [15:0] OFS_PORT_D_DATA = 16'h0005;
    localparam logic [15:0] OFS_PORT_C_DIR  = 16'h0006;
    localparam logic [15:0] OFS_PORT_D_DIR  = 16'h0007;
    localparam logic [15:0] OFS_PORT_E_DATA = 16'h0008;
    localparam logic [15:0] OFS_PORT_E_DIR  = 16'h0009;
    localparam logic [15:0] OFS_PORT_E_ASGN = 16'h000A;
    localparam logic [15:0] OFS_MODE        = 16'h000B;
    localparam logic [15:0] OFS_MISC        = 16'h0013;
    localparam logic [15:0] OFS_WINCTL      = 16'h0037;
    // field positions
    localparam int MODE_EMUL_D_BIT   = 1;
    localparam int MODE_EMUL_E_BIT   = 0;
    localparam int MISC_XWIN_POS_BIT = 3;
    localparam int MISC_NARROW_BIT   = 2;
    localparam int WDEF_XWIN_BIT     = 7;
    localparam int WDEF_DWEN_BIT  = 6;
    localparam int WDEF_PWEN_BIT  = 5;
    // reset values
    localparam logic [7:0] RST_MISC   = 8'h00;
    localparam logic [7:0] RST_WINCTL = 8'h00;
    localparam logic [7:0] RST_PORT_E_ASSIGNMENT_REG   = 8'h00;
    localparam logic [7:0] RST_PORT   = 8'h00;
    localparam logic [1:0] RST_EMUL   = 2'h0;
    // address ranges
    localparam logic [15:0] REG_LO  = 16'h0000;
    localparam logic [15:0] REG_HI  = 16'h01FF;
    localparam logic [15:0] RCS_LO  = 16'h0200;
    localparam logic [15:0] RCS_HI  = 16'h03FF;
    localparam logic [15:0] RAM_LO  = 16'h0800;
    localparam logic [15:0] RAM_HI  = 16'h0BFF;
    localparam logic [15:0] EEX_LO  = 16'h1000;
    localparam logic [15:0] EEX_HI  = 16'h1FFF;
    localparam logic [15:0] EES_LO  = 16'hF000;
    localparam logic [15:0] EES_HI  = 16'hFFFF;
    localparam logic [15:0] EWD_LO  = 16'h0000;
    localparam logic [15:0] EWD_HI  = 16'h03FF;
    localparam logic [15:0] EWI_LO  = 16'h0400;
    localparam logic [15:0] EWI_HI  = 16'h07FF;
    localparam logic [15:0] DWIN_LO = 16'h7000;
    localparam logic [15:0] DWIN_HI = 16'h7FFF;
    localparam logic [15:0] PWIN_LO = 16'h8000;
    localparam logic [15:0] PWIN_HI = 16'hBFFF;

    // {special_mode_latch_n, mode_select_pin_b, mode_select_pin_a}
    typedef enum logic [2:0] {
        MODE_SPC_SINGLE = 3'b000,
        MODE_SPC_NARROW = 3'b001,
        MODE_SPC_PERIPH = 3'b010,
        MODE_SPC_WIDE   = 3'b011,
        MODE_NRM_SINGLE = 3'b100,
        MODE_NRM_NARROW = 3'b101,
        MODE_NRM_RSVD   = 3'b110,
        MODE_NRM_WIDE   = 3'b111
    } op_mode_t;

    typedef struct packed {
        logic addr_ab;
        logic data_c;
        logic data_d;
        logic pe_bus;
        logic pe_bit3_high;
        logic pf_bit5_cs;
    } port_role_t;

    typedef struct packed {
        logic reg_blk;
        logic ram;
        logic eeprom;
        logic xpage;
        logic win_data;
        logic win_prog;
        logic rcs_narrow;
        logic external;
    } map_sel_t;
endpackage

// ### mode_map_port.sv
// mode latch, default memory map decode and port role selection
// assumes mode pins are asynchronous; register port and cpu address share clock_i
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module mode_map_port (
    input  wire logic                      clock_i,
    input  wire logic                      nrst_i,
    input  wire logic                      ce_i,
    input  wire logic                      background_mode_pin_i,
    input  wire logic                      mode_select_pin_a_i,
    input  wire logic                      mode_select_pin_b_i,
    input  wire logic [15:0]               addr_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [7:0]                rdata_o,
    output logic                           ext_cycle_o,
    input  wire logic [15:0]               cpu_addr_i,
    input  wire logic [3:0]                register_following_selects_i,
    input  wire logic [7:0]                port_a_pins_i,
    output logic      [7:0]                port_a_pins_o,
    output logic      [7:0]                port_a_pins_oe_o,
    output logic      [7:0]                port_e_func_o,
    output mode_map_pkg::port_role_t       role_o,
    output mode_map_pkg::map_sel_t         sel_o,
    output logic      [2:0]                mode_o
);
    import mode_map_pkg::*;

    logic [2:0] pin_s1_ff;
    logic [2:0] pin_s2_ff;
    logic [7:0] pa_s1_ff;
    logic [7:0] pa_s2_ff;
    logic       caught_ff;
    op_mode_t   mode_ff;
    logic [1:0] emul_ff;
    logic [7:0] misc_ff;
    logic       misc_wr_ff;
    logic [7:0] winctl_ff;
    logic [7:0] port_e_assignment_reg_ff;
    logic [7:0] pa_data_ff;
    logic [7:0] pa_dir_ff;

    // mode attributes
    wire expanded    = mode_ff[0];
    wire narrow      = mode_ff[0] & ~mode_ff[1];
    wire special     = ~mode_ff[2];
    wire peripheral  = (mode_ff == MODE_SPC_PERIPH);
    wire nrm_narrow  = (mode_ff == MODE_NRM_NARROW);
    wire emul_d      = emul_ff[MODE_EMUL_D_BIT];
    wire emul_e      = emul_ff[MODE_EMUL_E_BIT];
    wire xwin_en     = winctl_ff[WDEF_XWIN_BIT];
    wire xwin_pos    = misc_ff[MISC_XWIN_POS_BIT];
    wire narrow_spc  = misc_ff[MISC_NARROW_BIT];

    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic d_reg_f(input logic [15:0] a);
        d_reg_f = (a == OFS_PORT_D_DATA) || (a == OFS_PORT_D_DIR);
    endfunction

    // register taken out of the on-chip map under the current mode
    function automatic logic removed(input logic [15:0] a);
        logic pa_reg;
        logic cd_reg;
        logic d_reg;
        logic e_reg;
        pa_reg  = (a == OFS_PORT_A_DATA) || (a == OFS_PORT_A_DIR);
        d_reg   = d_reg_f(a);
        cd_reg  = (a == OFS_PORT_C_DATA) || (a == OFS_PORT_C_DIR) || d_reg;
        e_reg   = (a == OFS_PORT_E_DATA) || (a == OFS_PORT_E_DIR);
        removed = (pa_reg & (expanded | peripheral))
                | (cd_reg & expanded & ~narrow)
                | (d_reg & narrow & special & emul_d)
                | (e_reg & expanded & emul_e);
    endfunction

    // register port decode
    wire gone       = removed(addr_i);
    wire hit_pa     = (addr_i == OFS_PORT_A_DATA) & ~gone;
    wire hit_pdir   = (addr_i == OFS_PORT_A_DIR) & ~gone;
    wire hit_mode   = (addr_i == OFS_MODE);
    wire hit_misc   = (addr_i == OFS_MISC);
    wire hit_wdef   = (addr_i == OFS_WINCTL);
    wire hit_port_e_assignment_reg   = (addr_i == OFS_PORT_E_ASGN);
    wire misc_open  = special | ~misc_wr_ff;
    wire [7:0] pa_rd = (pa_dir_ff & pa_data_ff) | (~pa_dir_ff & pa_s2_ff);
    wire [7:0] rd_mux = hit_pa   ? pa_rd :
                        hit_pdir ? pa_dir_ff :
                        hit_mode ? {mode_ff, 3'h0, emul_ff} :
                        hit_misc ? misc_ff :
                        hit_wdef ? winctl_ff :
                        hit_port_e_assignment_reg ? port_e_assignment_reg_ff : 8'h00;

    // cpu address decode
    wire cpu_gone  = removed(cpu_addr_i);
    wire d_reg     = in_rng(cpu_addr_i, REG_LO, REG_HI) & ~cpu_gone;
    wire d_ram     = in_rng(cpu_addr_i, RAM_LO, RAM_HI);
    wire d_eep     = expanded ? in_rng(cpu_addr_i, EEX_LO, EEX_HI)
                              : in_rng(cpu_addr_i, EES_LO, EES_HI);
    wire d_xpage   = expanded & xwin_en & ~d_reg &
                     (xwin_pos ? in_rng(cpu_addr_i, EWD_LO, EWD_HI)
                               : in_rng(cpu_addr_i, EWI_LO, EWI_HI));
    wire d_dwin    = expanded & winctl_ff[WDEF_DWEN_BIT] &
                     in_rng(cpu_addr_i, DWIN_LO, DWIN_HI);
    wire d_pwin    = expanded & winctl_ff[WDEF_PWEN_BIT] &
                     in_rng(cpu_addr_i, PWIN_LO, PWIN_HI);
    wire d_rcsn    = expanded & ~narrow & narrow_spc & (|register_following_selects_i) &
                     in_rng(cpu_addr_i, RCS_LO, RCS_HI);
    wire d_ext     = expanded & ~d_reg & ~d_ram & ~d_eep;
    map_sel_t nxt_sel;
    assign nxt_sel = '{reg_blk: d_reg, ram: d_ram, eeprom: d_eep, xpage: d_xpage,
                       win_data: d_dwin, win_prog: d_pwin, rcs_narrow: d_rcsn,
                       external: d_ext};

    // port roles
    port_role_t nxt_role;
    assign nxt_role = '{addr_ab: expanded,
                        data_c: expanded,
                        data_d: expanded & (~narrow | emul_d),
                        pe_bus: expanded & ~emul_e,
                        pe_bit3_high: nrm_narrow,
                        pf_bit5_cs: expanded};
    wire [7:0] nxt_pa_o  = expanded ? cpu_addr_i[15:8] : pa_data_ff;
    wire [7:0] nxt_pa_oe = expanded ? 8'hFF : pa_dir_ff;
    wire [7:0] nxt_pe_fn = (expanded & ~emul_e) ? ~port_e_assignment_reg_ff : 8'h00;

    // mode pins keep sampling through reset so the capture sees settled levels
    always_ff @(posedge clock_i) begin
        if (ce_i) begin
            pin_s1_ff <= {background_mode_pin_i, mode_select_pin_b_i, mode_select_pin_a_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // port A pin synchroniser
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            pa_s1_ff  <= 8'h00;
            pa_s2_ff  <= 8'h00;
        end else if (ce_i) begin
            pa_s1_ff  <= port_a_pins_i;
            pa_s2_ff  <= pa_s1_ff;
        end
    end

    // mode pins caught once, on the first enabled edge after release
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            caught_ff <= 1'b0;
            mode_ff   <= MODE_SPC_SINGLE;
        end else if (ce_i && !caught_ff) begin
            caught_ff <= 1'b1;
            mode_ff   <= op_mode_t'(pin_s2_ff);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            emul_ff    <= RST_EMUL;
            misc_ff    <= RST_MISC;
            misc_wr_ff <= 1'b0;
            winctl_ff  <= RST_WINCTL;
            port_e_assignment_reg_ff    <= RST_PORT_E_ASSIGNMENT_REG;
        end else if (ce_i && wr_i) begin
            if (hit_mode)
                emul_ff <= wdata_i[1:0];
            if (hit_misc && misc_open) begin
                misc_ff    <= wdata_i;
                misc_wr_ff <= 1'b1;
            end
            if (hit_wdef)
                winctl_ff <= wdata_i;
            if (hit_port_e_assignment_reg)
                port_e_assignment_reg_ff <= wdata_i;
        end
    end

    // port A registers, untouched while removed
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            pa_data_ff <= RST_PORT;
            pa_dir_ff  <= RST_PORT;
        end else if (ce_i && wr_i) begin
            if (hit_pa)
                pa_data_ff <= wdata_i;
            if (hit_pdir)
                pa_dir_ff <= wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            rdata_o          <= 8'h00;
            ext_cycle_o      <= 1'b0;
            port_a_pins_o    <= 8'h00;
            port_a_pins_oe_o <= 8'h00;
            port_e_func_o    <= 8'h00;
            role_o           <= '0;
            sel_o            <= '0;
            mode_o           <= 3'h0;
        end else if (ce_i) begin
            rdata_o          <= rd_i ? rd_mux : 8'h00;
            ext_cycle_o      <= (rd_i | wr_i) & gone;
            port_a_pins_o    <= nxt_pa_o;
            port_a_pins_oe_o <= nxt_pa_oe;
            port_e_func_o    <= nxt_pe_fn;
            role_o           <= nxt_role;
            sel_o            <= nxt_sel;
            mode_o           <= mode_ff;
        end
    end

    // checks
    a_mode_caught_once: assert property (@(posedge clock_i) disable iff (!nrst_i)
        caught_ff && $past(caught_ff) |-> $stable(mode_ff))
        else $error("mode changed after capture");
    a_mode_from_pins: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && !caught_ff |=> mode_ff == $past(pin_s2_ff))
        else $error("mode not taken from pins");
    a_addr_role: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && caught_ff && expanded |=> role_o.addr_ab && role_o.pf_bit5_cs)
        else $error("expanded mode without address or select role");
    a_single_input: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && !expanded && pa_dir_ff == 8'h00 |=> port_a_pins_oe_o == 8'h00)
        else $error("single-chip port A driven without direction");
    a_ram_window: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && cpu_addr_i == RAM_LO |=> sel_o.ram && !sel_o.eeprom)
        else $error("ram base not decoded");
    a_eeprom_place: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && !expanded && cpu_addr_i == EES_LO |=> sel_o.eeprom)
        else $error("single-chip eeprom not decoded");
    a_misc_once: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && !special && misc_wr_ff |=> $stable(misc_ff))
        else $error("second mapping write took effect in normal mode");
    a_xpage_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && expanded && xwin_en && !xwin_pos && cpu_addr_i == EWI_LO
        |=> sel_o.xpage)
        else $error("extra window not at upper position");
    a_narrow_ignored: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && narrow |=> !sel_o.rcs_narrow)
        else $error("narrow space bit acted in narrow mode");
    a_removed_keep: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && wr_i && gone && addr_i == OFS_PORT_A_DATA
        |=> $stable(pa_data_ff) ##0 ext_cycle_o)
        else $error("removed register written or no external cycle");
endmodule

// ### ext_bus_model.sv
// external peripheral model facing the port A pins of the mode and map block
// assumes pin levels, enables and port roles come from the block under test
`timescale 1ns/1ns
module ext_bus_model #(
    parameter logic [7:0] IDLE_PATTERN = 8'h3C
) (
    input  wire logic                     clock_i,
    input  wire logic [7:0]               drv_i,
    input  wire logic [7:0]               oe_i,
    input  wire mode_map_pkg::port_role_t role_i,
    output logic      [7:0]               level_o,
    output logic      [7:0]               addr_seen_o
);
    import mode_map_pkg::*;
    // block wins where enabled, peripheral pattern on released pins
    assign level_o = (oe_i & drv_i) | (~oe_i & IDLE_PATTERN);
    // upper address capture while port A is the address bus
    always_ff @(posedge clock_i) begin
        if (role_i.addr_ab) begin
            addr_seen_o <= drv_i;
        end
    end
endmodule

// ### tb_mode_map_port.sv
// self-checking testbench for the mode, map and port setup block
// assumes one 100 MHz clock and the external pin model on port A
`timescale 1ns/1ns
module tb_mode_map_port;
    import mode_map_pkg::*;
    logic        clock_i, nrst_i, ce_i, bg_i, ma_i, mb_i, wr_i, rd_i, ext_cycle_o, ev;
    logic [15:0] addr_i, cpu_addr_i;
    logic [7:0]  wdata_i, rdata_o, pa_i, pa_o, pa_oe, pe_func, addr_seen, rv;
    logic [3:0]  rfs_i;
    logic [2:0]  mode_o;
    port_role_t  role_o;
    map_sel_t    sel_o;
    int          mismatches, cmp_count;

    mode_map_port DUT (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .background_mode_pin_i(bg_i), .mode_select_pin_a_i(ma_i), .mode_select_pin_b_i(mb_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ext_cycle_o(ext_cycle_o), .cpu_addr_i(cpu_addr_i), .register_following_selects_i(rfs_i),
        .port_a_pins_i(pa_i), .port_a_pins_o(pa_o), .port_a_pins_oe_o(pa_oe),
        .port_e_func_o(pe_func), .role_o(role_o), .sel_o(sel_o), .mode_o(mode_o));
    ext_bus_model ext (.clock_i(clock_i), .drv_i(pa_o), .oe_i(pa_oe), .role_i(role_o),
        .level_o(pa_i), .addr_seen_o(addr_seen));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic boot(input logic [2:0] m);
        @(posedge clock_i);
        bg_i <= m[2];
        mb_i <= m[1];
        ma_i <= m[0];
        nrst_i <= 1'b0;
        repeat (12) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
    endtask
    // one register cycle; answer sampled in the cycle after the strobe
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
        rv = rdata_o;
        ev = ext_cycle_o;
    endtask
    task automatic dec(input logic [15:0] a);
        @(posedge clock_i);
        cpu_addr_i <= a;
        @(posedge clock_i);
        #1;
    endtask
    task automatic t_modes;
        logic [2:0] m;
        logic       e;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            e = m[0];
            if (m == 3'b110) continue;
            boot(m);
            chk("mode", 16'(mode_o), 16'(m));
            chk("role", 16'(role_o), 16'({e, e, e & m[1], e, m == 3'b101, e}));
            chk("pe func", 16'(pe_func), e ? 16'h00FF : 16'h0000);
            dec(16'h1000);
            chk("eeprom lo", 16'(sel_o.eeprom), 16'(e));
            dec(16'hF000);
            chk("eeprom hi", 16'(sel_o.eeprom), 16'(!e));
            chk("pa oe", 16'(pa_oe), e ? 16'h00FF : 16'h0000);
            dec(16'h01FF);
            chk("reg blk", 16'(sel_o.reg_blk), 16'h0001);
            dec(16'h0BFF);
            chk("ram", 16'(sel_o.ram), 16'h0001);
            dec(16'h0C00);
            chk("ram end", 16'(sel_o.ram), 16'h0000);
            chk("ext", 16'(sel_o.external), 16'(e));
        end
        $display("test modes done");
    endtask
    task automatic t_window;
        boot(3'b111);
        acc(1'b1, OFS_MISC, 8'h08);
        acc(1'b1, OFS_MISC, 8'h04);
        acc(1'b0, OFS_MISC, 8'h00);
        chk("misc once", 16'(rv), 16'h0008);
        boot(3'b011);
        acc(1'b1, OFS_WINCTL, 8'h80);
        acc(1'b1, OFS_MISC, 8'h08);
        dec(16'h0300);
        chk("win direct", 16'(sel_o.xpage), 16'h0001);
        dec(16'h0500);
        chk("win other", 16'(sel_o.xpage), 16'h0000);
        acc(1'b1, OFS_MISC, 8'h00);
        acc(1'b0, OFS_MISC, 8'h00);
        chk("misc again", 16'(rv), 16'h0000);
        dec(16'h0500);
        chk("win upper", 16'(sel_o.xpage), 16'h0001);
        acc(1'b1, OFS_WINCTL, 8'h60);
        dec(16'h0500);
        chk("win off", 16'(sel_o.xpage), 16'h0000);
        dec(16'h7000);
        chk("data win", 16'(sel_o.win_data), 16'h0001);
        dec(16'h8000);
        chk("prog win", 16'({sel_o.win_prog, sel_o.external}), 16'h0003);
        rfs_i <= 4'h0;
        acc(1'b1, OFS_MISC, 8'h04);
        dec(16'h0200);
        chk("narrow no cs", 16'(sel_o.rcs_narrow), 16'h0000);
        rfs_i <= 4'h8;
        dec(16'h0200);
        chk("narrow cs", 16'(sel_o.rcs_narrow), 16'h0001);
        boot(3'b001);
        acc(1'b1, OFS_MISC, 8'h04);
        dec(16'h0200);
        chk("narrow bus", 16'(sel_o.rcs_narrow), 16'h0000);
        $display("test window done");
    endtask
    task automatic t_emul;
        boot(3'b011);
        acc(1'b0, OFS_PORT_C_DATA, 8'h00);
        chk("c ext", 16'(ev), 16'h0001);
        acc(1'b0, OFS_PORT_D_DIR, 8'h00);
        chk("d ext", 16'(ev), 16'h0001);
        boot(3'b001);
        acc(1'b0, OFS_PORT_D_DATA, 8'h00);
        chk("d int", 16'(ev), 16'h0000);
        acc(1'b1, OFS_MODE, 8'h02);
        acc(1'b0, OFS_PORT_D_DIR, 8'h00);
        chk("d emul", 16'(ev), 16'h0001);
        acc(1'b0, OFS_PORT_E_DATA, 8'h00);
        chk("e int", 16'(ev), 16'h0000);
        acc(1'b1, OFS_PORT_E_ASGN, 8'h0F);
        acc(1'b0, OFS_MODE, 8'h00);
        chk("pe asgn", 16'(pe_func), 16'h00F0);
        acc(1'b1, OFS_MODE, 8'h01);
        acc(1'b0, OFS_MODE, 8'h00);
        chk("mode reg", 16'(rv), 16'h0021);
        chk("pe emul", 16'(pe_func), 16'h0000);
        acc(1'b0, OFS_PORT_E_DIR, 8'h00);
        chk("e emul", 16'(ev), 16'h0001);
        $display("test emulation done");
    endtask
    task automatic t_port_a_pin_data;
        boot(3'b100);
        acc(1'b1, OFS_PORT_A_DIR, 8'hF0);
        acc(1'b1, OFS_PORT_A_DATA, 8'hA5);
        acc(1'b0, OFS_PORT_A_DIR, 8'h00);
        chk("dir rd", 16'(rv), 16'h00F0);
        chk("dir oe", 16'(pa_oe), 16'h00F0);
        acc(1'b0, OFS_PORT_A_DATA, 8'h00);
        chk("data rd", 16'(rv), 16'h00AC);
        chk("pin out", 16'(pa_o[7:4]), 16'h000A);
        boot(3'b111);
        dec(16'hC300);
        chk("addr out", 16'(pa_o), 16'h00C3);
        acc(1'b1, OFS_PORT_A_DATA, 8'h55);
        chk("a ext", 16'(ev), 16'h0001);
        acc(1'b0, OFS_PORT_A_DIR, 8'h00);
        chk("a dir ext", 16'({ev, rv}), 16'h0100);
        chk("addr seen", 16'(addr_seen), 16'h00C3);
        @(posedge clock_i);
        ce_i <= 1'b0;
        dec(16'h0800);
        chk("ce hold", 16'(sel_o.ram), 16'h0000);
        ce_i <= 1'b1;
        $display("test port a done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        finish_test;
    end
    initial begin
        {nrst_i, bg_i, ma_i, mb_i, wr_i, rd_i} = 6'h00;
        ce_i = 1'b1;
        addr_i = 16'h0000;
        cpu_addr_i = 16'h0000;
        wdata_i = 8'h00;
        rfs_i = 4'h0;
        t_modes;
        t_window;
        t_emul;
        t_port_a_pin_data;
        finish_test;
    end
endmodule
